// >>> rtl/host_port_pkg.sv
package host_port_pkg;

  // ------------------------------------------------------------
  // Widths and addresses
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int WORD_W = 32;
  localparam int FIFO_ADDR_LSB = 2;  // A[2:1] kept in FIFO mode -> index bits [1:0]
  localparam logic [1:0] SYNC_RESET = 2'h3;

  // ------------------------------------------------------------
  // Bus-side types
  // ------------------------------------------------------------
  typedef struct packed {
    logic chipSelectLow;
    logic readStrobeLow;
    logic writeStrobeLow;
  } strobes_t;

  typedef struct packed {
    logic fifoSel;
    logic [ADDR_W-1:0] addr;
  } target_t;

  // Internal 32-bit request toward registers or FIFOs
  typedef struct packed {
    logic valid;
    logic write;
    logic toFifo;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } core_req_t;

  // Interrupt configuration
  typedef struct packed {
    logic activeHigh;
    logic openDrain;
    logic enable;
  } irq_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } bus_state_t;

endpackage

// >>> rtl/strobe_sync.sv
`timescale 1ns/10ps
module strobe_sync (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire host_port_pkg::strobes_t pinIn,
  output host_port_pkg::strobes_t syncOut
);

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  // ------------------------------------------------------------
  // Two flops; inactive (high) after reset so nothing fires
  // ------------------------------------------------------------
  always_comb begin
    state_d.stage1 = pinIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule

// >>> rtl/sram_style_host_port.sv
`timescale 1ns/10ps
module sram_style_host_port (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire host_port_pkg::strobes_t pinStrobes,
  input wire logic [host_port_pkg::ADDR_W-1:0] hostAddr,
  input wire logic fifoSel,
  input wire logic [host_port_pkg::DATA_W-1:0] dataIn,
  output logic [host_port_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  output host_port_pkg::core_req_t coreReq,
  input wire logic [host_port_pkg::WORD_W-1:0] coreRdData,
  input wire logic bigEndian,
  input wire logic powerDown,
  output logic asleep,
  input wire host_port_pkg::irq_cfg_t irqCfg,
  input wire logic [7:0] irqSources,
  input wire logic [7:0] irqEnables,
  output logic irqOut,
  output logic irqOe
);

  typedef struct packed {
    host_port_pkg::bus_state_t st;
    logic [host_port_pkg::ADDR_W-1:0] addr;
    logic fifo;
    logic [host_port_pkg::DATA_W-1:0] dout;
    logic drive;
    logic [host_port_pkg::DATA_W-1:0] lowHalf;
    logic [host_port_pkg::DATA_W-1:0] highRead;
    logic readSeen;
    logic asleep;
    host_port_pkg::core_req_t req;
    logic [1:0] inSync1;
    logic [1:0] inSync2;
    logic [host_port_pkg::DATA_W-1:0] dinSync1;
    logic [host_port_pkg::DATA_W-1:0] dinSync2;
    logic [host_port_pkg::ADDR_W-1:0] addrSync1;
    logic [host_port_pkg::ADDR_W-1:0] addrSync2;
    logic [7:0] srcSync1;
    logic [7:0] srcSync2;
    logic irqLevel;
  } port_state_t;

  port_state_t s_q;
  port_state_t s_d;
  host_port_pkg::strobes_t strobes;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] swapBytes(input logic [15:0] v);
    swapBytes = {v[7:0], v[15:8]};
  endfunction

  function automatic logic upperHalf(input logic [6:0] a);
    upperHalf = a[0];
  endfunction

  // Register path follows host byte order; FIFO data is never swapped
  function automatic logic [15:0] hostOrder(input logic [15:0] v, input logic swap);
    hostOrder = swap ? swapBytes(v) : v;
  endfunction

  // Chip select and strobes cross here
  strobe_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(pinStrobes),
    .syncOut(strobes)
  );

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic selRead;
  logic selWrite;
  logic [6:0] effAddr;
  logic [15:0] inHalf;
  logic [15:0] outHalf;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.req.valid = 1'b0;
    outHalf = '0;
    // Address and data are stable well before the strobe lands, yet still
    // pass two flops so no mixed value reaches the core.
    s_d.inSync1 = {fifoSel, powerDown};
    s_d.inSync2 = s_q.inSync1;
    s_d.dinSync1 = dataIn;
    s_d.dinSync2 = s_q.dinSync1;
    s_d.addrSync1 = hostAddr;
    s_d.addrSync2 = s_q.addrSync1;
    s_d.srcSync1 = irqSources;
    s_d.srcSync2 = s_q.srcSync1;

    // Only the synchronised copies are decoded
    selRead = !strobes.chipSelectLow && !strobes.readStrobeLow;
    selWrite = !strobes.chipSelectLow && !strobes.writeStrobeLow;
    // FIFO window keeps only A2 and the halfword bit A1
    effAddr = s_q.inSync2[1] ? {5'h00, s_q.addrSync2[1:0]} : s_q.addrSync2;
    inHalf = hostOrder(s_q.dinSync2, bigEndian && !s_q.inSync2[1]);

    if (s_q.inSync2[0] && !s_q.asleep) begin
      s_d.asleep = 1'b1;
    end
    // Wake only on a host write; wake event pin plays no part
    if (s_q.asleep && selWrite) begin
      // The wake write itself is lost; a read must precede the next write
      s_d.asleep = 1'b0;
      s_d.readSeen = 1'b0;
    end

    unique case (s_q.st)
      host_port_pkg::ST_IDLE: begin
        if (selRead) begin
          s_d.st = host_port_pkg::ST_READ;
          s_d.addr = effAddr;
          s_d.fifo = s_q.inSync2[1];
          s_d.readSeen = !s_q.asleep;
          s_d.drive = 1'b1;
          // Low half fetches the word; high half comes from the latch so a
          // FIFO pop happens once per 32-bit word.
          if (!upperHalf(effAddr)) begin
            s_d.req = '{valid: !s_q.asleep, write: 1'b0, toFifo: s_q.inSync2[1],
                        addr: effAddr, data: '0};
            outHalf = coreRdData[15:0];
            s_d.highRead = coreRdData[31:16];
          end else begin
            outHalf = s_q.highRead;
          end
          s_d.dout = hostOrder(outHalf, bigEndian && !s_q.inSync2[1]);
        end else if (selWrite) begin
          s_d.st = host_port_pkg::ST_WRITE;
          // Writes before the first read are dropped; asleep also drops data
          if (s_q.readSeen && !s_q.asleep) begin
            if (!upperHalf(effAddr)) begin
              s_d.lowHalf = inHalf;
            end else begin
              s_d.req = '{valid: 1'b1, write: 1'b1, toFifo: s_q.inSync2[1],
                          addr: {effAddr[6:1], 1'b0}, data: {inHalf, s_q.lowHalf}};
            end
          end
        end
      end
      host_port_pkg::ST_READ: begin
        // Bus released on the edge after the strobe is seen high
        if (!selRead) begin
          s_d.st = host_port_pkg::ST_IDLE;
          s_d.drive = 1'b0;
        end
      end
      host_port_pkg::ST_WRITE: begin
        if (!selWrite) begin
          s_d.st = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = host_port_pkg::ST_IDLE;
      end
    endcase

    // Entering sleep cancels a request taken in the same cycle, so the core
    // never sees traffic while asleep; the host repeats it after waking
    if (s_d.asleep && !s_q.asleep) begin
      s_d.req.valid = 1'b0;
    end

    // Sources come through two flops; enables are already on this clock
    s_d.irqLevel = irqCfg.enable && |(s_q.srcSync2 & irqEnables);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign dataOut = s_q.dout;
  assign dataOe = !s_q.drive;
  assign coreReq = s_q.req;
  assign asleep = s_q.asleep;

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  // Open drain only ever pulls low, so polarity is forced active-low there
  always_comb begin
    if (irqCfg.openDrain) begin
      irqOut = 1'b0;
      irqOe = !s_q.irqLevel;
    end else begin
      irqOut = irqCfg.activeHigh ? s_q.irqLevel : !s_q.irqLevel;
      irqOe = 1'b0;
    end
  end

endmodule

// >>> bench/host_port_sva.sv
`timescale 1ns/10ps
module host_port_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire host_port_pkg::strobes_t pinStrobes,
  input wire logic fifoSel,
  input wire logic [host_port_pkg::DATA_W-1:0] dataIn,
  input wire logic dataOe,
  input wire host_port_pkg::core_req_t coreReq,
  input wire logic bigEndian,
  input wire logic powerDown,
  input wire logic asleep,
  input wire host_port_pkg::irq_cfg_t irqCfg,
  input wire logic irqOut,
  input wire logic irqOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sync_delay_a: assert property ($fell(pinStrobes.readStrobeLow) && !pinStrobes.chipSelectLow |->
      dataOe ##1 dataOe)
    else $error("read answered too early");
  read_answer_a: assert property ($fell(dataOe) |-> $past(pinStrobes, 2) == 3'h1)
    else $error("data driven without read");
  idle_quiet_a: assert property (pinStrobes.chipSelectLow [*5] |-> dataOe && !coreReq.valid)
    else $error("activity while unselected");
  fifo_route_a: assert property (coreReq.valid |->
      coreReq.toFifo == fifoSel && (!fifoSel || coreReq.addr[6:2] == 5'h0))
    else $error("fifo routing wrong");
  word_pair_a: assert property (coreReq.valid && coreReq.write && !bigEndian |->
      (!coreReq.addr[0] && coreReq.data[31:16] == dataIn) ##1 !coreReq.valid)
    else $error("write word wrong");
  wake_write_a: assert property (asleep && !powerDown && $fell(pinStrobes.writeStrobeLow) &&
      !pinStrobes.chipSelectLow |-> ##[1:6] !asleep)
    else $error("no wake on write");
  sleep_quiet_a: assert property (asleep |-> !coreReq.valid)
    else $error("core request while asleep");
  push_pull_a: assert property (!irqCfg.openDrain && $past(irqCfg.openDrain, 2) == 1'b0 |-> !irqOe)
    else $error("push-pull not driven");
  open_drain_a: assert property (irqCfg.openDrain && $past(irqCfg.openDrain, 2) |-> !irqOut)
    else $error("open drain drives high");
endmodule
bind sram_style_host_port host_port_sva chk (.ref_clk(ref_clk), .rstn(rstn), .pinStrobes(pinStrobes),
  .fifoSel(fifoSel), .dataIn(dataIn), .dataOe(dataOe), .coreReq(coreReq), .bigEndian(bigEndian),
  .powerDown(powerDown), .asleep(asleep), .irqCfg(irqCfg), .irqOut(irqOut), .irqOe(irqOe));

// >>> bench/host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic ref_clk,
  input wire logic dataOe,
  input wire logic [15:0] dataOut,
  output host_port_pkg::strobes_t pinStrobes,
  output logic [6:0] hostAddr,
  output logic [15:0] dataIn
);
  logic lastOe;
  initial begin
    pinStrobes = 3'h7;
    hostAddr = 7'h0;
    dataIn = 16'h0;
    lastOe = 1'b1;
  end
  // Five cycles each way keeps clear of the two-flop sync
  task automatic acc(input logic sel, input logic wr, input logic [6:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge ref_clk);
    hostAddr = a;
    dataIn = d;
    pinStrobes = {!sel, wr, !wr};
    repeat (5) @(negedge ref_clk);
    q = dataOut;
    lastOe = dataOe;
    pinStrobes = 3'h7;
    hostAddr = ~a;
    dataIn = ~d;
    repeat (5) @(negedge ref_clk);
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic ref_clk, rstn, fifoSel, dataOe, bigEndian, powerDown, asleep, irqOut, irqOe;
  host_port_pkg::strobes_t pinStrobes;
  logic [6:0] hostAddr;
  logic [15:0] dataIn, dataOut, q;
  host_port_pkg::core_req_t coreReq, lastReq;
  logic [31:0] coreRdData;
  host_port_pkg::irq_cfg_t irqCfg;
  logic [7:0] irqSources, irqEnables;
  int errCount, totalChecks, wrCnt;
  sram_style_host_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .pinStrobes(pinStrobes), .hostAddr(hostAddr),
    .fifoSel(fifoSel), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .coreReq(coreReq),
    .coreRdData(coreRdData), .bigEndian(bigEndian), .powerDown(powerDown), .asleep(asleep), .irqCfg(irqCfg),
    .irqSources(irqSources), .irqEnables(irqEnables), .irqOut(irqOut), .irqOe(irqOe));
  host_model i_host (.ref_clk(ref_clk), .dataOe(dataOe), .dataOut(dataOut), .pinStrobes(pinStrobes),
    .hostAddr(hostAddr), .dataIn(dataIn));
  always @(posedge ref_clk) begin
    if (coreReq.valid === 1'b1) begin
      lastReq <= coreReq;
      wrCnt += (coreReq.write === 1'b1);
    end
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    totalChecks++;
    if (s !== e) begin
      errCount++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic summarize();
    if (errCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_rw();
    i_host.acc(1, 1, 7'h20, 16'h1111, q);
    i_host.acc(1, 1, 7'h21, 16'h2222, q);
    chk("early write", wrCnt, 0);
    i_host.acc(0, 0, 7'h10, 16'h0, q);
    chk("unselected", i_host.lastOe, 1);
    i_host.acc(1, 0, 7'h10, 16'h0, q);
    chk("low half", q, 16'habcd);
    chk("fetch", {lastReq.write, lastReq.addr}, 8'h10);
    i_host.acc(1, 0, 7'h11, 16'h0, q);
    chk("high half", q, 16'h1234);
    i_host.acc(1, 1, 7'h20, 16'h5678, q);
    chk("latched", wrCnt, 0);
    i_host.acc(1, 1, 7'h21, 16'h9abc, q);
    chk("word", {lastReq.toFifo, lastReq.addr, lastReq.data}, {8'h20, 32'h9abc5678});
    fifoSel = 1'b1;
    i_host.acc(1, 1, 7'h7c, 16'h0f0f, q);
    i_host.acc(1, 1, 7'h7d, 16'hf0f0, q);
    chk("fifo", {lastReq.toFifo, lastReq.addr, lastReq.data}, {8'h80, 32'hf0f00f0f});
    fifoSel = 1'b0;
  endtask
  task automatic t_sleep();
    powerDown = 1'b1;
    repeat (6) @(negedge ref_clk);
    powerDown = 1'b0;
    i_host.acc(1, 0, 7'h10, 16'h0, q);
    chk("read keeps sleep", asleep, 1);
    i_host.acc(1, 1, 7'h20, 16'h3333, q);
    chk("woken", {asleep, wrCnt[3:0]}, 5'h2);
    i_host.acc(1, 1, 7'h20, 16'h4444, q);
    i_host.acc(1, 1, 7'h21, 16'h5555, q);
    chk("no read yet", wrCnt, 2);
    i_host.acc(1, 0, 7'h10, 16'h0, q);
    i_host.acc(1, 1, 7'h20, 16'h6666, q);
    i_host.acc(1, 1, 7'h21, 16'h7777, q);
    chk("after read", wrCnt, 3);
  endtask
  task automatic t_irq();
    logic [2:0] cfgTab [8] = '{3'h5, 3'h5, 3'h1, 3'h1, 3'h3, 3'h3, 3'h5, 3'h4};
    logic [1:0] expTab [8] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 8; i++) begin
      irqCfg = cfgTab[i];
      irqSources = (i[0] && i < 7) ? 8'h00 : 8'h04;
      irqEnables = (i == 6) ? 8'hfb : 8'hff;
      repeat (6) @(negedge ref_clk);
      chk("irq pin", {irqOut, irqOe}, expTab[i]);
    end
  endtask
  task automatic t_endian();
    bigEndian = 1'b1;
    i_host.acc(1, 0, 7'h10, 16'h0, q);
    chk("swapped read", q, 16'hcdab);
    i_host.acc(1, 1, 7'h20, 16'h1122, q);
    i_host.acc(1, 1, 7'h21, 16'h3344, q);
    chk("swapped word", {lastReq.toFifo, lastReq.addr, lastReq.data}, {8'h20, 32'h44332211});
    fifoSel = 1'b1;
    i_host.acc(1, 0, 7'h7c, 16'h0, q);
    chk("fifo unswapped", {q, lastReq.toFifo, lastReq.addr}, {16'habcd, 8'h80});
    fifoSel = 1'b0;
    bigEndian = 1'b0;
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    @(negedge ref_clk);
    chk("reset outputs", {dataOe, asleep, coreReq.valid}, 3'h4);
    rstn = 1'b1;
    i_host.acc(1, 1, 7'h20, 16'h1111, q);
    i_host.acc(1, 1, 7'h21, 16'h2222, q);
    chk("write after reset", wrCnt, 4);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    summarize();
  end
  initial begin
    {rstn, fifoSel, bigEndian, powerDown} = 4'h0;
    {errCount, totalChecks, wrCnt} = '0;
    coreRdData = 32'h1234abcd;
    irqCfg = 3'h5;
    irqSources = 8'h00;
    irqEnables = 8'hff;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    t_rw();
    t_sleep();
    t_endian();
    t_reset();
    t_irq();
    summarize();
  end
endmodule
